// file: hw/cbm_control.v
// Basic-mode control, command, status, interrupt and acceptance logic of a
// bus controller, plus the small receive descriptor FIFO it owns.
// Assumes a protocol engine on the same clock that shifts bits, keeps the
// error counters and frame bytes, and talks to this block by pulses/levels.
`timescale 1ns/100ps
`default_nettype none
`include "cbm_map.vh"

// ==========================================================================
// Descriptor FIFO
module cbm_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter IDXW = 2
) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Filling side
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  // Draining side
  output wire [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  localparam [IDXW:0] FULL_COUNT = DEPTH[IDXW:0];
  localparam [IDXW-1:0] LAST_IDX = DEPTH[IDXW-1:0] - 1'b1;
  reg [WIDTH-1:0] memReg [0:DEPTH-1];
  reg [IDXW-1:0] wrIdxReg;
  reg [IDXW-1:0] rdIdxReg;
  reg [IDXW:0] countReg;
  wire push;
  wire pop;
  wire [IDXW:0] countNext;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign countNext = countReg + {{IDXW{1'b0}}, push} - {{IDXW{1'b0}}, pop};
  assign outData = memReg[rdIdxReg];

  // Full and empty kept as flops so the ready and valid ports are clean
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      countReg <= {(IDXW+1){1'b0}};
      wrIdxReg <= {IDXW{1'b0}};
      rdIdxReg <= {IDXW{1'b0}};
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      countReg <= countNext;
      inReady <= countNext != FULL_COUNT;
      outValid <= countNext != {(IDXW+1){1'b0}};
      if (push) begin
        wrIdxReg <= (wrIdxReg == LAST_IDX) ? {IDXW{1'b0}} : wrIdxReg + 1'b1;
      end
      if (pop) begin
        rdIdxReg <= (rdIdxReg == LAST_IDX) ? {IDXW{1'b0}} : rdIdxReg + 1'b1;
      end
    end
  end

  // Storage needs no reset; valid gating hides stale words
  always @(posedge clock) begin
    if (push) begin
      memReg[wrIdxReg] <= inData;
    end
  end
endmodule

// ==========================================================================
// Control block top
module cbm_control (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // CPU register port
  input wire [4:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output reg cpuIrqLine,
  // Protocol engine control
  output reg engineHalt,
  output reg [7:0] bitTimingZero,
  output reg [7:0] bitTimingOne,
  output reg extendedMode,
  output reg errCountClear,
  // Transmit side
  output reg txRequest,
  input wire txStarted,
  input wire txActive,
  // Receive activity and counters
  input wire rxActive,
  input wire rxFrameStart,
  input wire rxFrameRcvd,
  input wire rxOverloadFrame,
  input wire busFree,
  input wire [8:0] txErrCount,
  input wire [7:0] rxErrCount,
  // Received message descriptors
  input wire rxMsgValid,
  input wire [7:0] rxMsgId,
  input wire [7:0] rxMsgHandle,
  input wire rxMsgOverrun,
  output wire rxMsgReady,
  output reg [7:0] rxHeadHandle
);
  // Control and configuration state
  reg [4:0] controlReg;
  reg [7:0] accCodeReg;
  reg [7:0] accMaskReg;
  // Status state
  reg rbsReg;
  reg orsReg;
  reg tbsReg;
  reg overloadReg;
  reg esReg;
  reg busOffReg;
  reg bsPrevReg;
  reg recoverReg;
  reg [7:0] freeCountReg;
  reg headShownReg;
  reg ovrPendReg;
  reg [3:0] irqFlagsReg;
  // Next values and decodes
  reg [7:0] readNext;
  wire resetMode;
  wire wrCtl;
  wire wrCmd;
  wire wrCfg;
  wire rdIrq;
  wire cmdTx;
  wire cmdCancel;
  wire cmdRelease;
  wire cmdClrOvr;
  wire busOffEnter;
  wire recoverDone;
  wire filterPass;
  wire fifoInReady;
  wire [8:0] fifoHead;
  wire fifoValid;
  wire releasePop;
  wire headNew;
  wire rbsNext;
  wire tbsNext;
  wire esNext;
  wire orsNext;
  wire txRequestNext;
  wire [3:0] irqSet;

  // Filter compare: only unmasked positions must match the code
  function accept;
    input [7:0] id;
    input [7:0] code;
    input [7:0] mask;
    begin
      accept = ((id ^ code) & ~mask) == 8'h00;
    end
  endfunction

  // Counts at or above the warning level
  function atWarn;
    input [8:0] count;
    begin
      atWarn = count >= `CBM_WARN_LIMIT;
    end
  endfunction

  // ========================================================================
  // Register decode
  assign resetMode = controlReg[`CBM_CTL_RESET];
  assign wrCtl = regWrite && regAddr == `CBM_OFS_CONTROL;
  assign wrCmd = regWrite && regAddr == `CBM_OFS_COMMAND && !resetMode;
  assign wrCfg = regWrite && resetMode;
  assign rdIrq = regRead && regAddr == `CBM_OFS_IRQ_FLAGS;
  // Zero bits are no action; bits exist only in the write cycle
  assign cmdTx = wrCmd && regWrData[`CBM_CMD_TX_REQ];
  assign cmdCancel = wrCmd && regWrData[`CBM_CMD_CANCEL];
  assign cmdRelease = wrCmd && regWrData[`CBM_CMD_RELEASE];
  assign cmdClrOvr = wrCmd && regWrData[`CBM_CMD_CLR_OVR];

  // ========================================================================
  // Bus-off entry and recovery
  assign busOffEnter = txErrCount[8] && !busOffReg && !errCountClear;
  assign recoverDone = recoverReg && !resetMode && busFree &&
    freeCountReg == `CBM_BUS_FREE_COUNT - 8'h01;

  // ========================================================================
  // Receive path
  assign filterPass = accept(rxMsgId, accCodeReg, accMaskReg);
  assign rxMsgReady = fifoInReady;
  assign releasePop = cmdRelease && fifoValid;
  assign headNew = fifoValid && !headShownReg && !releasePop;

  // Rejected descriptors are taken but not stored
  cbm_fifo #(
    .WIDTH(9),
    .DEPTH(4),
    .IDXW(2)
  ) rxQueue (
    .clock(clock),
    .arst_n(arst_n),
    .inData({rxMsgOverrun | ovrPendReg, rxMsgHandle}),
    .inValid(rxMsgValid && filterPass && !resetMode),
    .inReady(fifoInReady),
    .outData(fifoHead),
    .outValid(fifoValid),
    .outReady(releasePop)
  );

  // ========================================================================
  // Status next values and edge causes
  assign rbsNext = releasePop ? 1'b0 : fifoValid;
  assign tbsNext = !(txRequestNext || txActive || txStarted);
  assign esNext = atWarn(txErrCount) || atWarn({1'b0, rxErrCount});
  // Set wins over the clear command
  assign orsNext = (headNew && fifoHead[8]) || (orsReg && !cmdClrOvr);
  assign txRequestNext = resetMode ? 1'b0 :
    txStarted ? 1'b0 :
    cmdCancel ? 1'b0 :
    (cmdTx && tbsReg) ? 1'b1 : txRequest;
  assign irqSet[0] = rbsNext && !rbsReg && controlReg[`CBM_CTL_RX_IE];
  assign irqSet[1] = tbsNext && !tbsReg && controlReg[`CBM_CTL_TX_IE];
  assign irqSet[2] = ((esNext != esReg) || (busOffReg != bsPrevReg)) &&
    controlReg[`CBM_CTL_ERR_IE];
  assign irqSet[3] = orsNext && !orsReg && controlReg[`CBM_CTL_OVR_IE];

  // ========================================================================
  // Control register and configuration
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      controlReg <= `CBM_RST_CONTROL;
      accCodeReg <= `CBM_RST_ZERO8;
      accMaskReg <= `CBM_RST_ZERO8;
      bitTimingZero <= `CBM_RST_ZERO8;
      bitTimingOne <= `CBM_RST_ZERO8;
      extendedMode <= 1'b0;
    end else begin
      if (wrCtl) begin
        controlReg <= regWrData[4:0];
      end
      // Hardware bus-off entry beats a software clear in the same cycle
      if (busOffEnter) begin
        controlReg[`CBM_CTL_RESET] <= 1'b1;
      end
      if (wrCfg && regAddr == `CBM_OFS_ACC_CODE) begin
        accCodeReg <= regWrData;
      end
      if (wrCfg && regAddr == `CBM_OFS_ACC_MASK) begin
        accMaskReg <= regWrData;
      end
      if (wrCfg && regAddr == `CBM_OFS_TIMING_ZERO) begin
        bitTimingZero <= regWrData;
      end
      if (wrCfg && regAddr == `CBM_OFS_TIMING_ONE) begin
        bitTimingOne <= regWrData;
      end
      if (wrCfg && regAddr == `CBM_OFS_MODE_SELECT) begin
        extendedMode <= regWrData[`CBM_MODE_EXT];
      end
    end
  end

  // ========================================================================
  // Transmit, receive and bus-off state
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txRequest <= 1'b0;
      engineHalt <= 1'b1;
      errCountClear <= 1'b0;
      busOffReg <= 1'b0;
      bsPrevReg <= 1'b0;
      recoverReg <= 1'b0;
      freeCountReg <= 8'h00;
      headShownReg <= 1'b0;
      ovrPendReg <= 1'b0;
      rxHeadHandle <= 8'h00;
    end else begin
      txRequest <= txRequestNext;
      engineHalt <= busOffEnter ||
        (wrCtl ? regWrData[`CBM_CTL_RESET] : resetMode);
      errCountClear <= recoverDone;
      bsPrevReg <= busOffReg;
      if (busOffEnter) begin
        busOffReg <= 1'b1;
        recoverReg <= 1'b1;
        freeCountReg <= 8'h00;
      end else if (recoverDone) begin
        busOffReg <= 1'b0;
        recoverReg <= 1'b0;
        freeCountReg <= 8'h00;
      end else if (recoverReg && !resetMode && busFree) begin
        freeCountReg <= freeCountReg + 8'h01;
      end
      // Head shown once; a release makes the next one new
      if (releasePop) begin
        headShownReg <= 1'b0;
      end else if (fifoValid) begin
        headShownReg <= 1'b1;
      end
      if (headNew) begin
        rxHeadHandle <= fifoHead[7:0];
      end
      // A frame starting with no room marks the next descriptor taken, which may be one already waiting
      if (rxMsgValid && fifoInReady) begin
        ovrPendReg <= 1'b0;
      end else if (rxFrameStart && !fifoInReady) begin
        ovrPendReg <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Status bits and interrupt flags
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rbsReg <= 1'b0;
      tbsReg <= 1'b0;
      esReg <= 1'b0;
      orsReg <= 1'b0;
      overloadReg <= 1'b0;
      irqFlagsReg <= 4'h0;
      cpuIrqLine <= 1'b0;
    end else begin
      rbsReg <= rbsNext;
      tbsReg <= tbsNext;
      esReg <= esNext;
      orsReg <= orsNext;
      // Overload set wins over a data frame in the same cycle
      if (rxOverloadFrame) begin
        overloadReg <= 1'b1;
      end else if (rxFrameRcvd) begin
        overloadReg <= 1'b0;
      end
      // Read clears, but a cause in the read cycle survives
      irqFlagsReg <= (rdIrq ? 4'h0 : irqFlagsReg) | irqSet;
      cpuIrqLine <= |((rdIrq ? 4'h0 : irqFlagsReg) | irqSet);
    end
  end

  // ========================================================================
  // Read mux; code, mask and timing registers answer all ones in operating mode
  always @* begin
    case (regAddr)
      `CBM_OFS_CONTROL: readNext = {3'h0, controlReg};
      `CBM_OFS_COMMAND: readNext = `CBM_READ_COMMAND;
      `CBM_OFS_STATUS: readNext = {busOffReg, esReg, txActive, rxActive,
        overloadReg, tbsReg, orsReg, rbsReg};
      `CBM_OFS_IRQ_FLAGS: readNext = {4'h0, irqFlagsReg};
      `CBM_OFS_ACC_CODE: readNext = resetMode ? accCodeReg :
        `CBM_READ_LOCKED;
      `CBM_OFS_ACC_MASK: readNext = resetMode ? accMaskReg :
        `CBM_READ_LOCKED;
      `CBM_OFS_TIMING_ZERO: readNext = resetMode ? bitTimingZero :
        `CBM_READ_LOCKED;
      `CBM_OFS_TIMING_ONE: readNext = resetMode ? bitTimingOne :
        `CBM_READ_LOCKED;
      `CBM_OFS_MODE_SELECT: readNext = {extendedMode, 7'h00};
      default: readNext = 8'h00;
    endcase
  end

  // Read data held until the next read
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= readNext;
    end
  end
endmodule
`default_nettype wire

// file: hw/cbm_map.vh
// Register map, field positions, reset values and counts of the basic-mode
// control block. Included by the design file; definitions only.
`ifndef CBM_MAP_VH
`define CBM_MAP_VH
// ==========================================================================
// Register offsets
`define CBM_OFS_CONTROL 5'h00
`define CBM_OFS_COMMAND 5'h01
`define CBM_OFS_STATUS 5'h02
`define CBM_OFS_IRQ_FLAGS 5'h03
`define CBM_OFS_ACC_CODE 5'h04
`define CBM_OFS_ACC_MASK 5'h05
`define CBM_OFS_TIMING_ZERO 5'h06
`define CBM_OFS_TIMING_ONE 5'h07
`define CBM_OFS_MODE_SELECT 5'h1f
// ==========================================================================
// Control register fields
`define CBM_CTL_RESET 0
`define CBM_CTL_RX_IE 1
`define CBM_CTL_TX_IE 2
`define CBM_CTL_ERR_IE 3
`define CBM_CTL_OVR_IE 4
// Command register fields
`define CBM_CMD_TX_REQ 0
`define CBM_CMD_CANCEL 1
`define CBM_CMD_RELEASE 2
`define CBM_CMD_CLR_OVR 3
// Mode select field
`define CBM_MODE_EXT 7
// ==========================================================================
// Reset values and fixed answers
`define CBM_RST_CONTROL 5'h01
`define CBM_RST_ZERO8 8'h00
`define CBM_READ_LOCKED 8'hff
`define CBM_READ_COMMAND 8'hff
// ==========================================================================
// Counts
`define CBM_WARN_LIMIT 9'h060
`define CBM_BUS_FREE_COUNT 8'h80
`endif

// file: tb/cbm_control_chk.sv
// Checker for the basic-mode control block, seeing only its top ports.
// Assumes binding from the bench top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checker
module cbm_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // Engine side
  input wire logic engineHalt,
  input wire logic [7:0] bitTimingZero,
  input wire logic txRequest,
  input wire logic txStarted,
  input wire logic txActive,
  input wire logic [8:0] txErrCount
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Decoded writes; the command one guards the transmit checks
  wire ctlWr = regWrite && regAddr == 5'h00;
  wire cmdWr = regWrite && regAddr == 5'h01;
  wire timWr = regWrite && regAddr == 5'h06;
  property p_halt;
    ctlWr && regWrData[0] |=> engineHalt;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_busoff;
    $rose(txErrCount[8]) |-> ##[0:2] engineHalt;
  endproperty
  a_busoff: assert property (p_busoff) else $error("no bus off");
  property p_tim_wr;
    timWr && engineHalt |=> bitTimingZero == $past(regWrData);
  endproperty
  a_tim_wr: assert property (p_tim_wr) else $error("timing lost");
  property p_tim_lock;
    timWr && !engineHalt |=> $stable(bitTimingZero);
  endproperty
  a_tim_lock: assert property (p_tim_lock) else $error("timing");
  property p_tx_go;
    cmdWr && regWrData[0] && !regWrData[1] && !engineHalt && !txRequest &&
      !txActive && !txStarted && !$past(txActive) && !$past(txStarted)
      |=> txRequest;
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("no request");
  property p_tx_keep;
    txRequest && !txStarted && !engineHalt && !(cmdWr && regWrData[1])
      |=> txRequest;
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("dropped");
  property p_tx_take;
    txRequest && txStarted |=> !txRequest;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("kept");
  property p_cmd_rd;
    regRead && regAddr == 5'h01 |=> regRdData == 8'hff;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("cmd read");
endmodule
`default_nettype wire

// file: tb/cbm_engine_model.sv
// Behavioural protocol engine at the far side of the control block.
// Assumes the block's clock; the bench loads counters and descriptors.
`timescale 1ns/100ps
`default_nettype none
// ====================
// Engine model
module cbm_engine_model #(parameter int TX_LEN = 20) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control from the block and the bench
  input wire logic engineHalt,
  input wire logic errCountClear,
  input wire logic txRequest,
  input wire logic txHold,
  input wire logic rxMsgReady,
  // Engine outputs
  output logic txStarted,
  output logic txActive,
  output logic [8:0] txErrCount,
  output logic [7:0] rxErrCount,
  output logic rxMsgValid,
  output logic [7:0] rxMsgId,
  output logic [7:0] rxMsgHandle,
  output logic rxMsgOverrun
);
  logic [16:0] q[$];
  int txLeft;
  // Queue a descriptor: overrun, identifier, handle
  task automatic push(input logic [16:0] d);
    q.push_back(d);
  endtask
  initial {txErrCount, rxErrCount, rxMsgOverrun, rxMsgId, rxMsgHandle} = '0;
  // Send when asked and not held; a halt cuts the frame short
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txStarted <= 1'b0;
      txActive <= 1'b0;
      txLeft <= 0;
    end else begin
      txStarted <= txRequest && !txHold && !txActive && !txStarted;
      txLeft <= txStarted ? TX_LEN : (txLeft > 0 ? txLeft - 1 : 0);
      txActive <= txStarted || (txActive && txLeft > 1 && !engineHalt);
    end
  end
  // Counters are zeroed on the block's order
  always @(posedge clock) if (errCountClear) {txErrCount, rxErrCount} <= '0;
  // One descriptor at a time; idle lines toggle so stale data never matches
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) rxMsgValid <= 1'b0;
    else if (!rxMsgValid && q.size() > 0) begin
      {rxMsgOverrun, rxMsgId, rxMsgHandle} <= q.pop_front();
      rxMsgValid <= 1'b1;
    end else if (!rxMsgValid || rxMsgReady) begin
      rxMsgValid <= 1'b0;
      {rxMsgOverrun, rxMsgId, rxMsgHandle} <=
        ~{rxMsgOverrun, rxMsgId, rxMsgHandle};
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the basic-mode control block with engine model.
// Assumes the checker and engine model files are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
// ====================
// Bench top
module tb;
  logic clock = 0, arst_n = 0, regWrite = 0, regRead = 0, txHold = 0;
  logic rxActive = 0, rxFrameStart = 0, rxFrameRcvd = 0, busFree = 0;
  logic rxOverloadFrame = 0, cpuIrqLine, engineHalt, extendedMode;
  logic errCountClear, txRequest, txStarted, txActive, rxMsgValid;
  logic rxMsgOverrun, rxMsgReady;
  logic [4:0] regAddr = 0;
  logic [7:0] regWrData = 0, regRdData, bitTimingZero, bitTimingOne, v, id;
  logic [7:0] rxMsgId, rxMsgHandle, rxErrCount, rxHeadHandle;
  logic [8:0] txErrCount;
  logic [7:0] expQ[$];
  int errors = 0, checked = 0, cycles = 0, seed = 32'hc07dc55c;
  cbm_control i_dut (.*);
  cbm_engine_model i_eng (.*);
  // 125 MHz clock
  initial forever #4 clock = ~clock;
  // Hang guard; the run needs under 3000 cycles
  always @(posedge clock) if (++cycles == 20000) begin
    errors++;
    stop_test();
  end
  // Register cycles: one-clock strobe, read data taken after it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clock);
    {regWrite, regAddr, regWrData} = {1'b1, a, d};
    @(negedge clock);
    regWrite = 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge clock);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clock);
    regRead = 0;
    v = regRdData;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1;
    @(negedge clock);
    s = 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    idle(5);
    arst_n = 1;
    rd(0); `CHK("control", 8'h01, v);
    rd(1); `CHK("command", 8'hff, v);
    rd(2); `CHK("status", 8'h04, v);
    rd(9); `CHK("unmapped", 8'h00, v);
    wr(4, 8'hc5);
    wr(5, 8'h0f);
    wr(6, 8'hc4);
    wr(7, 8'h34);
    wr(5'h1f, 8'h80);
    rd(5); `CHK("mask", 8'h0f, v);
    rd(5'h1f); `CHK("mode rd", 8'h80, v);
    wr(0, 8'h1e);
    rd(4); `CHK("code locked", 8'hff, v);
    rd(5); `CHK("mask locked", 8'hff, v);
    wr(6, 8'h11);
    wr(7, 8'h11);
    wr(5'h1f, 8'h00);
    `CHK("timing", 8'hc4, bitTimingZero);
    `CHK("timing one", 8'h34, bitTimingOne);
    `CHK("mode", 1'b1, extendedMode);
    rd(3); `CHK("flags idle", 8'h00, v);
    $display("registers done");
    // Transmit, then a cancelled request
    txHold = 1;
    wr(1, 8'h01);
    rd(2); `CHK("tbs pending", 1'b0, v[2]);
    txHold = 0;
    while (txActive !== 1'b1) @(negedge clock);
    rd(2); `CHK("sending", 1'b1, v[5]);
    while (txActive !== 1'b0) @(negedge clock);
    idle(2);
    `CHK("irq", 1'b1, cpuIrqLine);
    rd(3); `CHK("flags tx", 8'h02, v);
    idle(1);
    `CHK("irq off", 1'b0, cpuIrqLine);
    txHold = 1;
    wr(1, 8'h01);
    wr(1, 8'h00);
    `CHK("zero cmd", 1'b1, txRequest);
    wr(1, 8'h02);
    idle(2);
    `CHK("cancelled", 1'b0, txRequest);
    rd(3); `CHK("flags cancel", 8'h02, v);
    txHold = 0;
    $display("transmit done");
    // Filtered reception through the FIFO
    for (int i = 0; i < 6; i++) begin
      id = $random(seed);
      if (i[0]) id[7:4] = 4'hc;
      if (((id ^ 8'hc5) & ~8'h0f) == 0) expQ.push_back(i[7:0]);
      i_eng.push({1'b0, id, i[7:0]});
    end
    rxActive = 1;
    rd(2); `CHK("receiving", 1'b1, v[4]);
    rxActive = 0;
    while (expQ.size() > 0) begin
      idle(6);
      id = expQ.pop_front();
      rd(2); `CHK("rbs", 1'b1, v[0]);
      `CHK("head", id, rxHeadHandle);
      wr(1, 8'h04);
    end
    idle(6);
    rd(2); `CHK("rbs empty", 1'b0, v[0]);
    rd(3); `CHK("flags rx", 8'h01, v);
    i_eng.push({1'b1, 8'hc5, 8'h77});
    idle(6);
    rd(2); `CHK("overrun", 2'b11, v[1:0]);
    rd(3); `CHK("flags ovr", 8'h09, v);
    wr(1, 8'h08);
    rd(2); `CHK("overrun clr", 2'b01, v[1:0]);
    wr(1, 8'h04);
    // A frame starting while four messages are held marks the next one
    for (int i = 0; i < 5; i++) i_eng.push({1'b0, 8'hc0, i[7:0]});
    idle(12);
    `CHK("fifo full", 1'b0, rxMsgReady);
    pulse(rxFrameStart);
    for (int i = 0; i < 5; i++) begin
      rd(2); `CHK("late overrun", {i == 4, 1'b1}, v[1:0]);
      if (i == 4) wr(1, 8'h08);
      wr(1, 8'h04);
      idle(2);
    end
    rd(3); `CHK("flags late", 8'h09, v);
    $display("receive done");
    // Warning level, overload and bus-off recovery
    i_eng.rxErrCount = 8'd96;
    rd(2); `CHK("warning", 1'b1, v[6]);
    rd(3); `CHK("flags err", 8'h04, v);
    i_eng.rxErrCount = 8'd95;
    rd(2); `CHK("warning off", 1'b0, v[6]);
    rd(3); `CHK("flags err off", 8'h04, v);
    pulse(rxOverloadFrame);
    rd(2); `CHK("overload", 1'b1, v[3]);
    pulse(rxFrameRcvd);
    rd(2); `CHK("overload clr", 1'b0, v[3]);
    i_eng.txErrCount = 9'd256;
    idle(3);
    rd(0); `CHK("forced reset", 8'h1f, v);
    rd(2); `CHK("bus off", 2'b11, v[7:6]);
    wr(0, 8'h1e);
    repeat (127) pulse(busFree);
    rd(2); `CHK("still off", 1'b1, v[7]);
    pulse(busFree);
    idle(3);
    rd(2); `CHK("bus on", 2'b00, v[7:6]);
    `CHK("counters", 9'd0, txErrCount);
    rd(3); `CHK("flags on", 8'h04, v);
    $display("error handling done");
    stop_test();
  end
endmodule
bind cbm_control cbm_chk i_chk (.*);
`default_nettype wire
